// ==== rtl/grt_defines.vh ====
`ifndef GRT_DEFINES_VH
`define GRT_DEFINES_VH
// Power states
`define GRT_FULL_POWER_STATE   1'b0
`define GRT_LIGHT_LOAD_STATE   1'b1
// Command codes on the decoded command port
`define GRT_CMD_W              3
`define GRT_CMD_SET_PS         3'h1
`define GRT_CMD_VID_FAST       3'h2
`define GRT_CMD_VID_SLOW       3'h3
`define GRT_CMD_REG_READ       3'h4
// Register addresses
`define GRT_ADDR_W             8
`define GRT_REG_STATUS1        8'h10
`define GRT_REG_THERMAL_ZONE   8'h12
// Status register 1 field
`define GRT_ST1_THERMAL_BIT    1
// Zone bit positions
`define GRT_ZONE_ALERT_SET     6
`define GRT_ZONE_ALERT_CLR     5
`define GRT_ZONE_HOT_SET       7
`define GRT_ZONE_HOT_CLR       6
// Comp current codes in microamps
`define GRT_COMP_OFF           4'h0
`define GRT_COMP_FAST_UA       4'h8
`define GRT_COMP_SLOW_UA       4'h2
// Response codes: ack or reject
`define GRT_RESP_ACK           2'h0
`define GRT_RESP_REJECT        2'h1
`endif

// ==== rtl/grt_rail_thermal.v ====
// Summary of operation
// - Capture offset-pin comparator level once after each reset release.
// - Start in full-power state after reset until a power-state command.
// - Set-power-state command changes the operating state immediately.
// - Light-load state drives single-phase mode with diode emulation enabled.
// - Any voltage-change command forces return to full-power state.
// - After reaching target stay full-power; only new power-state command reenters light-load.
// - Fast upward transition selects 8 uA compensation current.
// - Slow upward transition selects 2 uA compensation current.
// - Downward transition keeps compensation current off.
// - Thermal comparator bank digitised into the zone register.
// - Zone register is a thermometer code, bit i per threshold.
// - While monitoring is enabled, zone bit 6 rising sets thermal alert and status bit 1.
// - Alert and status bit 1 clear when zone bit 5 falls or thermal monitoring is disabled.
// - Status bit 1 tracks alert, unlatched; register reads never clear it.
// - While monitoring is enabled, zone bit 7 rising asserts hot indicator low.
// - Hot indicator releases when zone bit 6 falls or thermal monitoring is disabled.
// - With thermal monitoring disabled, zone-register commands are rejected.
`timescale 1ns/1ps
`include "grt_defines.vh"
module grt_rail_thermal #(
  parameter ZONE_W = 8
) (
  input  wire                   clk_in,           // Core clock, 100 MHz
  input  wire                   rst_n_in,         // Async reset, active low
  input  wire                   offset_pin_in,    // Offset pin above 0.6 V comparator
  input  wire [ZONE_W-1:0]      temp_sense_pin_in,// Thermal comparator outputs
  input  wire                   sense_disable_in, // Sense pin tied to five volt supply
  input  wire                   other_alert_in,   // Other alert sources, high active
  input  wire                   at_target_in,     // Output reached its target voltage
  input  wire                   cmd_valid_in,     // Command strobe from serial decoder
  input  wire [`GRT_CMD_W-1:0]  cmd_code_in,      // Command code
  input  wire [`GRT_ADDR_W-1:0] cmd_addr_in,      // Register address
  input  wire [7:0]             cmd_data_in,      // Payload: power state or VID
  output reg                    offset_en_out,    // Latched pin offset enable
  output reg                    power_state_out,  // 0 full power, 1 light load
  output reg                    diode_emulation_out, // Diode emulation enable
  output reg                    single_phase_out, // Single-phase operation
  output reg  [3:0]             comp_current_out, // Compensation current in uA
  output reg                    alert_n_out,      // Shared alert, active low
  output reg                    alert_oe_out,     // Alert pin output enable
  output reg                    hot_indicator_n_out, // Hot indicator, active low
  output reg                    hot_oe_out,       // Hot pin output enable
  output reg  [ZONE_W-1:0]      zone_out,         // Thermal zone code
  output reg  [7:0]             status1_out,      // Status register 1
  output reg                    resp_valid_out,   // Response strobe
  output reg  [1:0]             resp_code_out,    // Ack or reject
  output reg  [7:0]             resp_data_out     // Read data
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers; first stage feeds only second stage
reg [ZONE_W-1:0] zone_s1_q;
reg [ZONE_W-1:0] zone_s2_q;
reg              ofs_s1_q;
reg              ofs_s2_q;
reg              dis_s1_q;
reg              dis_s2_q;
reg              oth_s1_q;
reg              oth_s2_q;

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    zone_s1_q <= {ZONE_W{1'b0}};
    zone_s2_q <= {ZONE_W{1'b0}};
    ofs_s1_q  <= 1'b0;
    ofs_s2_q  <= 1'b0;
    dis_s1_q  <= 1'b0;
    dis_s2_q  <= 1'b0;
    oth_s1_q  <= 1'b0;
    oth_s2_q  <= 1'b0;
  end else begin
    zone_s1_q <= temp_sense_pin_in;
    zone_s2_q <= zone_s1_q;
    ofs_s1_q  <= offset_pin_in;
    ofs_s2_q  <= ofs_s1_q;
    dis_s1_q  <= sense_disable_in;
    dis_s2_q  <= dis_s1_q;
    oth_s1_q  <= other_alert_in;
    oth_s2_q  <= oth_s1_q;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Thermometer encoding: a bit only counts if all lower bits are set, which
// masks a glitching comparator above a lower one that is clear
wire [ZONE_W-1:0] zone_d;
genvar gi;
generate
  for (gi = 0; gi < ZONE_W; gi = gi + 1) begin : g_zone
    assign zone_d[gi] = &zone_s2_q[gi:0];
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Offset capture after reset release
reg       ofs_done_q;
reg [1:0] ofs_wait_q;

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    ofs_done_q    <= 1'b0;
    ofs_wait_q    <= 2'h0;
    offset_en_out <= 1'b0;
  end else if (!ofs_done_q) begin
    // Wait for the synchroniser to fill before sampling
    ofs_wait_q <= ofs_wait_q + 2'h1;
    if (ofs_wait_q == 2'h2) begin
      offset_en_out <= ofs_s2_q;
      ofs_done_q    <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Power state and compensation current
wire cmd_ps   = cmd_valid_in && (cmd_code_in == `GRT_CMD_SET_PS);
wire cmd_fast = cmd_valid_in && (cmd_code_in == `GRT_CMD_VID_FAST);
wire cmd_slow = cmd_valid_in && (cmd_code_in == `GRT_CMD_VID_SLOW);
wire cmd_vid  = cmd_fast || cmd_slow;

reg [7:0] vid_q;
reg [7:0] vid_d;
reg       ramp_q;
reg       ramp_d;
reg       power_state_d;
reg       light_mode_d;
reg [3:0] comp_d;

// Next-state logic; a VID command outranks everything else
always @* begin
  vid_d         = vid_q;
  ramp_d        = ramp_q;
  power_state_d = power_state_out;
  light_mode_d  = diode_emulation_out;
  comp_d        = comp_current_out;
  if (cmd_vid) begin
    // An earlier light-load request is dropped, not resumed
    power_state_d = `GRT_FULL_POWER_STATE;
    light_mode_d  = 1'b0;
    vid_d         = cmd_data_in;
    ramp_d        = 1'b1;
    if (cmd_data_in > vid_q) begin
      comp_d = cmd_fast ? `GRT_COMP_FAST_UA : `GRT_COMP_SLOW_UA;
    end else begin
      comp_d = `GRT_COMP_OFF;
    end
  end else if (cmd_ps) begin
    power_state_d = cmd_data_in[0];
    light_mode_d  = cmd_data_in[0];
  end else if (ramp_q && at_target_in) begin
    // Ramp over: compensation only runs while the output slews
    ramp_d = 1'b0;
    comp_d = `GRT_COMP_OFF;
  end
end

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    power_state_out     <= `GRT_FULL_POWER_STATE;
    diode_emulation_out <= 1'b0;
    single_phase_out    <= 1'b0;
    comp_current_out    <= `GRT_COMP_OFF;
    vid_q               <= 8'h00;
    ramp_q              <= 1'b0;
  end else begin
    // Both light-load outputs follow one bit so they never disagree
    power_state_out     <= power_state_d;
    diode_emulation_out <= light_mode_d;
    single_phase_out    <= light_mode_d;
    comp_current_out    <= comp_d;
    vid_q               <= vid_d;
    ramp_q              <= ramp_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Thermal alert and hot indicator with hysteresis
reg  [ZONE_W-1:0] zone_prev_q;
reg               th_alert_q;
reg               th_alert_d;
reg               hot_q;
reg               hot_d;
reg  [7:0]        status1_d;

wire [ZONE_W-1:0] zone_rise = zone_d & ~zone_prev_q;
wire [ZONE_W-1:0] zone_fall = zone_prev_q & ~zone_d;
wire              th_on;
wire              hot_on;

// Set and clear watch different bits, so a sense voltage hovering
// at one threshold cannot make the outputs chatter
always @* begin
  th_alert_d = th_alert_q;
  if (zone_rise[`GRT_ZONE_ALERT_SET]) begin
    th_alert_d = 1'b1;
  end else if (zone_fall[`GRT_ZONE_ALERT_CLR]) begin
    th_alert_d = 1'b0;
  end
end

always @* begin
  hot_d = hot_q;
  if (zone_rise[`GRT_ZONE_HOT_SET]) begin
    hot_d = 1'b1;
  end else if (zone_fall[`GRT_ZONE_HOT_CLR]) begin
    hot_d = 1'b0;
  end
end

// Monitoring off silences both thermal outputs
assign th_on  = th_alert_d && !dis_s2_q;
assign hot_on = hot_d && !dis_s2_q;

always @* begin
  status1_d = 8'h00;
  // Unlatched: reads have no path into this bit
  status1_d[`GRT_ST1_THERMAL_BIT] = th_on;
end

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    zone_prev_q         <= {ZONE_W{1'b0}};
    th_alert_q          <= 1'b0;
    hot_q               <= 1'b0;
    zone_out            <= {ZONE_W{1'b0}};
    status1_out         <= 8'h00;
    alert_n_out         <= 1'b1;
    alert_oe_out        <= 1'b0;
    hot_indicator_n_out <= 1'b1;
    hot_oe_out          <= 1'b0;
  end else begin
    zone_prev_q <= zone_d;
    th_alert_q  <= th_alert_d;
    hot_q       <= hot_d;
    zone_out    <= zone_d;
    status1_out <= status1_d;
    // Open drain: only ever drives low
    alert_n_out  <= 1'b0;
    alert_oe_out <= th_on || oth_s2_q;
    hot_indicator_n_out <= 1'b0;
    hot_oe_out          <= hot_on;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Command responses
wire       zone_addr = (cmd_addr_in == `GRT_REG_THERMAL_ZONE);
wire       reg_read  = (cmd_code_in == `GRT_CMD_REG_READ);
// Monitoring off: everything aimed at the zone register is refused
wire       reject    = zone_addr && dis_s2_q;

reg  [7:0] read_word;
reg  [1:0] resp_code_d;
reg  [7:0] resp_data_d;

// Read mux; unknown addresses read as zero
always @* begin
  case (cmd_addr_in)
    `GRT_REG_THERMAL_ZONE: begin
      read_word = zone_out;
    end
    `GRT_REG_STATUS1: begin
      read_word = status1_out;
    end
    default: begin
      read_word = 8'h00;
    end
  endcase
end

// Code and data hold between commands
always @* begin
  resp_code_d = resp_code_out;
  resp_data_d = resp_data_out;
  if (cmd_valid_in) begin
    resp_data_d = 8'h00;
    if (reject) begin
      // Rejected commands return no data
      resp_code_d = `GRT_RESP_REJECT;
    end else begin
      resp_code_d = `GRT_RESP_ACK;
      if (reg_read) begin
        resp_data_d = read_word;
      end
    end
  end
end

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    resp_valid_out <= 1'b0;
    resp_code_out  <= `GRT_RESP_ACK;
    resp_data_out  <= 8'h00;
  end else begin
    resp_valid_out <= cmd_valid_in;
    resp_code_out  <= resp_code_d;
    resp_data_out  <= resp_data_d;
  end
end

endmodule

// ==== dv/grt_host_model.sv ====
`timescale 1ns/1ps
module grt_host_model (
  input  wire       clk_in,               // Core clock
  input  wire       resp_valid_in,        // Answer strobe
  input  wire [1:0] resp_code_in,         // Ack or reject
  input  wire [7:0] resp_data_in,         // Read data
  output reg        cmd_valid_out = 1'b0, // Command strobe
  output reg  [2:0] cmd_code_out = 3'h0,  // Command code
  output reg  [7:0] cmd_addr_out = 8'h00, // Register address
  output reg  [7:0] cmd_data_out = 8'h00  // Payload
);
  // Called at a falling edge; released address and payload go inverted so stale data never looks fresh
  task automatic send(input [2:0] c, input [7:0] a, d, output v, output [1:0] rc,
                      output [7:0] rd);
    cmd_code_out = c;
    cmd_addr_out = a;
    cmd_data_out = d;
    cmd_valid_out = 1'b1;
    @(negedge clk_in);
    v = resp_valid_in;
    rc = resp_code_in;
    rd = resp_data_in;
    cmd_valid_out = 1'b0;
    cmd_addr_out = ~a;
    cmd_data_out = ~d;
    @(negedge clk_in);
  endtask
endmodule

// ==== dv/grt_rail_thermal_properties.sv ====
`timescale 1ns/1ps
`include "grt_defines.vh"
module grt_rail_thermal_properties #(
  parameter ZONE_W = 8
) (
  input wire              clk_in,              // Clock
  input wire              rst_n_in,            // Reset
  input wire              sense_disable_in,    // Monitor off
  input wire              at_target_in,        // Ramp done
  input wire              cmd_valid_in,        // Strobe
  input wire [2:0]        cmd_code_in,         // Code
  input wire [7:0]        cmd_data_in,         // Payload
  input wire              power_state_out,     // State
  input wire              diode_emulation_out, // Diode mode
  input wire              single_phase_out,    // One phase
  input wire [3:0]        comp_current_out,    // Comp uA
  input wire              alert_oe_out,        // Alert drive
  input wire              hot_oe_out,          // Hot drive
  input wire [ZONE_W-1:0] zone_out,            // Zone code
  input wire [7:0]        status1_out          // Status
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  //////////////////////////////////////////////////////////////
  // Last VID code, to tell an upward ramp from a downward one
  reg  [7:0] vid_q;
  wire       vid_cmd = cmd_valid_in && (cmd_code_in == 3'h2 || cmd_code_in == 3'h3);
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) vid_q <= 8'h00;
    else if (vid_cmd) vid_q <= cmd_data_in;
  sequence s_vid_up;
    vid_cmd && !at_target_in && cmd_data_in > vid_q;
  endsequence
  // Mirrors the disable synchroniser plus one stage for the output register
  reg  [2:0] off_q;
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) off_q <= 3'h0;
    else off_q <= {off_q[1:0], sense_disable_in};
  //////////////////////////////////////////////////////////////
  a_light_diode: assert property (diode_emulation_out == power_state_out &&
    single_phase_out == power_state_out) else $error("light load mode mismatch");
  a_set_power_state_cmd_now: assert property (cmd_valid_in && cmd_code_in == 3'h1 |=>
    power_state_out == $past(cmd_data_in[0])) else $error("set state late");
  a_vid_full: assert property (vid_cmd |=> !power_state_out)
    else $error("vid left light load");
  a_comp_up: assert property (s_vid_up |=> comp_current_out ==
    ($past(cmd_code_in) == 3'h2 ? 4'h8 : 4'h2)) else $error("comp up wrong");
  a_comp_down: assert property (vid_cmd && cmd_data_in <= vid_q |=>
    comp_current_out == 4'h0) else $error("comp on going down");
  a_alert_set: assert property ($rose(zone_out[6]) && !off_q[2] |->
    alert_oe_out && status1_out[1]) else $error("alert not set");
  a_alert_clr: assert property ($fell(zone_out[5]) |-> !status1_out[1])
    else $error("alert not cleared");
  a_alert_hold: assert property ($past(status1_out[1]) && !$fell(zone_out[5]) &&
    !off_q[2] |-> status1_out[1]) else $error("alert dropped early");
  a_hot_set: assert property ($rose(zone_out[7]) && !off_q[2] |-> hot_oe_out)
    else $error("hot not set");
  a_hot_clr: assert property ($fell(zone_out[6]) |-> !hot_oe_out)
    else $error("hot not released");
  a_zone_thermo: assert property (((zone_out + 1'b1) & zone_out) == 0)
    else $error("zone not thermometer");
endmodule

// ==== dv/grt_rail_thermal_test.sv ====
`timescale 1ns/1ps
module grt_rail_thermal_test;
  reg        clk_in = 1'b0;
  reg        rst_n_in = 1'b0;
  reg        sd = 1'b0, oa = 1'b0, at = 1'b0, rv, ea = 1'b0, eh = 1'b0;
  reg        op = 1'b1;
  reg  [7:0] tp = 8'h00, ez, rdat;
  reg  [1:0] rc;
  int        failures = 0, samples_checked = 0, cycles = 0, n;
  wire       cv, offset_en, pst, diode_em, alert_oe, hot_oe, resp_v, sp, alert_n, hot_n;
  wire [2:0] cc;
  wire [3:0] comp;
  wire [1:0] resp_c;
  wire [7:0] ca, cd, zone, st1, resp_d;
  always #5 clk_in = ~clk_in;
  grt_rail_thermal i_grt_rail_thermal (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .offset_pin_in(op), .temp_sense_pin_in(tp), .sense_disable_in(sd),
    .other_alert_in(oa), .at_target_in(at), .cmd_valid_in(cv), .cmd_code_in(cc),
    .cmd_addr_in(ca), .cmd_data_in(cd), .offset_en_out(offset_en), .power_state_out(pst),
    .diode_emulation_out(diode_em), .single_phase_out(sp), .comp_current_out(comp),
    .alert_n_out(alert_n), .alert_oe_out(alert_oe),
    .hot_indicator_n_out(hot_n), .hot_oe_out(hot_oe),
    .zone_out(zone), .status1_out(st1), .resp_valid_out(resp_v), .resp_code_out(resp_c),
    .resp_data_out(resp_d));
  grt_host_model i_grt_host_model (.clk_in(clk_in), .resp_valid_in(resp_v),
    .resp_code_in(resp_c), .resp_data_in(resp_d), .cmd_valid_out(cv), .cmd_code_out(cc),
    .cmd_addr_out(ca), .cmd_data_out(cd));
  //////////////////////////////////////////////////////////////
  task check(input string nm, input [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task cmd(input [2:0] c, input [7:0] a, d);
    i_grt_host_model.send(c, a, d, rv, rc, rdat);
    check("resp_valid", rv, 8'h01);
  endtask
  task wn(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A hang counts as a failure rather than silently stalling the run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict;
    end
  end
  //////////////////////////////////////////////////////////////
  initial begin
    wn(4);
    rst_n_in = 1'b1;
    wn(4);
    check("power_state", pst, 8'h00);
    check("offset_en", offset_en, 8'h01);
    check("alert_n", alert_n, 8'h00);
    check("hot_n", hot_n, 8'h00);
    cmd(3'h1, 8'h00, 8'h01);
    check("power_state", pst, 8'h01);
    check("diode_em", diode_em, 8'h01);
    check("single_phase", sp, 8'h01);
    cmd(3'h2, 8'h00, 8'h40);
    check("power_state", pst, 8'h00);
    check("comp", comp, 8'h08);
    check("diode_em", diode_em, 8'h00);
    check("single_phase", sp, 8'h00);
    at = 1'b1;
    wn(1);
    at = 1'b0;
    wn(1);
    check("power_state", pst, 8'h00);
    check("comp", comp, 8'h00);
    cmd(3'h1, 8'h00, 8'h01);
    check("power_state", pst, 8'h01);
    cmd(3'h3, 8'h00, 8'h50);
    check("comp", comp, 8'h02);
    cmd(3'h2, 8'h00, 8'h10);
    check("comp", comp, 8'h00);
    $display("power state test done");
    for (int i = 0; i <= 16; i++) begin
      n = (i <= 8) ? i : 16 - i;
      ez = 8'hff >> (8 - n);
      tp = ez;
      wn(6);
      ea = ez[6] | (ea & ez[5]);
      eh = ez[7] | (eh & ez[6]);
      check("zone", zone, ez);
      check("alert_oe", alert_oe, ea);
      check("hot_oe", hot_oe, eh);
      check("status1", st1, {6'h00, ea, 1'b0});
      cmd(3'h4, 8'h12, 8'h00);
      check("zone_read", rdat, ez);
      cmd(3'h4, 8'h10, 8'h00);
      check("status1", rdat[1], ea);
    end
    $display("thermal test done");
    oa = 1'b1;
    wn(4);
    check("alert_oe", alert_oe, 8'h01);
    oa = 1'b0;
    wn(4);
    check("alert_oe", alert_oe, 8'h00);
    sd = 1'b1;
    wn(4);
    cmd(3'h4, 8'h12, 8'h00);
    check("resp_code", rc, 8'h01);
    cmd(3'h4, 8'h10, 8'h00);
    check("resp_code", rc, 8'h00);
    $display("alert and disable test done");
    cmd(3'h1, 8'h00, 8'h01);
    check("power_state", pst, 8'h01);
    op = 1'b0;
    wn(2);
    rst_n_in = 1'b0;
    wn(1);
    check("alert_n", alert_n, 8'h01);
    check("power_state", pst, 8'h00);
    wn(1);
    rst_n_in = 1'b1;
    wn(4);
    check("offset_en", offset_en, 8'h00);
    check("power_state", pst, 8'h00);
    $display("reset and offset test done");
    print_verdict;
  end
endmodule
bind grt_rail_thermal grt_rail_thermal_properties #(.ZONE_W(ZONE_W)) i_grt_rail_thermal_properties (
  .clk_in, .rst_n_in, .sense_disable_in, .at_target_in, .cmd_valid_in, .cmd_code_in,
  .cmd_data_in, .power_state_out, .diode_emulation_out, .single_phase_out,
  .comp_current_out, .alert_oe_out, .hot_oe_out, .zone_out, .status1_out);
